// file: core/high_side_switch_protection.sv
// control and protection logic for four high-side switches
`timescale 1ns/10ps
`default_nettype none
module high_side_switch_protection
  import hs_pkg::*;
#(
  parameter logic [CNT_W-1:0] OC_FILTER = OC_FILTER_CYCLES,
  parameter logic [CNT_W-1:0] OL_FILTER = OL_FILTER_CYCLES
) (
  // clock and reset
  input  wire logic                core_clk_i,
  input  wire logic                sys_rst_i,
  // register port
  input  wire logic [ADDR_W-1:0]   addr_i,
  input  wire logic [DATA_W-1:0]   wr_data_i,
  input  wire logic                wr_en_i,
  input  wire logic                rd_en_i,
  output logic      [DATA_W-1:0]   rd_data_o,
  // chip mode and internal sources
  input  wire chip_mode_type       chip_mode_i,
  input  wire logic [1:0]          timer_i,
  input  wire logic [1:0]          pwm_i,
  // analog comparators
  input  wire logic                supply_over_i,
  input  wire logic                supply_under_i,
  input  wire logic [NUM_OUT-1:0]  overcurrent_i,
  input  wire logic [NUM_OUT-1:0]  open_load_i,
  // switch drives
  output logic      [NUM_OUT-1:0]  high_side_output_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_OUT-1:0][CFG_W-1:0] cfg;
    logic [2:0]                    supply_cfg;
    logic [NUM_OUT-1:0]            oc_flag;
    logic [NUM_OUT-1:0]            ol_flag;
    logic                          over_flag;
    logic                          under_flag;
    logic [NUM_OUT-1:0][CNT_W-1:0] oc_cnt;
    logic [NUM_OUT-1:0][CNT_W-1:0] ol_cnt;
    logic [NUM_OUT-1:0]            drive;
    logic                          kill_prev;
    logic [DATA_W-1:0]             rd_data;
  } hs_state_type;

  hs_state_type st_reg;
  hs_state_type st_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic mode_kills(input chip_mode_type m);
    case (m)
      MODE_RESTART:   mode_kills = 1'b1;
      MODE_FAIL_SAFE: mode_kills = 1'b1;
      default:        mode_kills = 1'b0;
    endcase
  endfunction : mode_kills

  function automatic logic source_level(input logic [CFG_W-1:0] c,
                                        input logic [1:0]       tmr,
                                        input logic [1:0]       pwm);
    case (c)
      CFG_ON:     source_level = 1'b1;
      CFG_TIMER1: source_level = tmr[0];
      CFG_TIMER2: source_level = tmr[1];
      CFG_PWM1:   source_level = pwm[0];
      CFG_PWM2:   source_level = pwm[1];
      default:    source_level = 1'b0;
    endcase
  endfunction : source_level

  // ----------------------------------------------------------------
  // comparator synchronisation
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0]  sync_q;
  logic               over_s;
  logic               under_s;
  logic [NUM_OUT-1:0] oc_s;
  logic [NUM_OUT-1:0] ol_s;
  logic               kill;
  logic               low_power;
  logic               cutoff;
  logic               no_recover;
  logic               wr_ok;
  logic [NUM_OUT-1:0] oc_clr;
  logic [NUM_OUT-1:0] ol_clr;
  logic               sup_clr_ov;
  logic               sup_clr_uv;

  level_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({open_load_i, overcurrent_i, supply_under_i,
                 supply_over_i}),
    .sync_o    (sync_q)
  );

  assign over_s  = sync_q[0];
  assign under_s = sync_q[1];
  assign oc_s    = sync_q[5:2];
  assign ol_s    = sync_q[9:6];

  assign kill      = mode_kills(chip_mode_i);
  assign low_power = (chip_mode_i == MODE_LOW_POWER);
  assign cutoff    =
    (over_s & ~st_reg.supply_cfg[SUP_OV_DIS_BIT]) |
    (under_s & ~st_reg.supply_cfg[SUP_UV_DIS_BIT]);
  assign no_recover = ~st_reg.supply_cfg[SUP_RECOVER_BIT];
  assign wr_ok      = wr_en_i & ~low_power;

  // ----------------------------------------------------------------
  // status clears
  // ----------------------------------------------------------------
  always_comb begin
    oc_clr     = '0;
    ol_clr     = '0;
    sup_clr_ov = 1'b0;
    sup_clr_uv = 1'b0;
    if (wr_en_i) begin
      case (addr_i)
        ADDR_OC_STAT: oc_clr = wr_data_i[NUM_OUT-1:0];
        ADDR_OL_STAT: ol_clr = wr_data_i[NUM_OUT-1:0];
        ADDR_SUPPLY_STAT: begin
          sup_clr_ov = wr_data_i[STAT_OV_BIT];
          sup_clr_uv = wr_data_i[STAT_UV_BIT];
        end
        default: begin
          oc_clr = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // configuration writes, normal and kill modes only
    if (wr_ok) begin
      case (addr_i)
        ADDR_CTRL_A: begin
          st_next.cfg[0] = wr_data_i[CTRL_LO_POS +: CFG_W];
          st_next.cfg[1] = wr_data_i[CTRL_HI_POS +: CFG_W];
        end
        ADDR_CTRL_B: begin
          st_next.cfg[2] = wr_data_i[CTRL_LO_POS +: CFG_W];
          st_next.cfg[3] = wr_data_i[CTRL_HI_POS +: CFG_W];
        end
        ADDR_SUPPLY_CFG: begin
          st_next.supply_cfg = wr_data_i[2:0];
        end
        default: begin
          st_next.supply_cfg = st_reg.supply_cfg;
        end
      endcase
    end
    // entry into restart or fail-safe drops all control fields, supply config kept
    st_next.kill_prev = kill;
    if (kill && !st_reg.kill_prev) begin
      st_next.cfg = '0;
    end
    // supply cut without recovery clears control fields
    if (cutoff && no_recover) begin
      st_next.cfg = '0;
    end
    // supply flags, set wins over clear
    st_next.over_flag  = over_s | (st_reg.over_flag & ~sup_clr_ov);
    st_next.under_flag = under_s | (st_reg.under_flag & ~sup_clr_uv);
    // per-output protection
    for (int i = 0; i < NUM_OUT; i++) begin
      // over-current filter
      if (oc_s[i] && st_reg.drive[i]) begin
        if (st_reg.oc_cnt[i] != '1) begin
          st_next.oc_cnt[i] = st_reg.oc_cnt[i] + 10'h001;
        end
      end else begin
        st_next.oc_cnt[i] = '0;
      end
      // open-load filter, only while on
      if (ol_s[i] && st_reg.drive[i]) begin
        if (st_reg.ol_cnt[i] != '1) begin
          st_next.ol_cnt[i] = st_reg.ol_cnt[i] + 10'h001;
        end
      end else begin
        st_next.ol_cnt[i] = '0;
      end
      st_next.oc_flag[i] = st_reg.oc_flag[i] & ~oc_clr[i];
      st_next.ol_flag[i] = st_reg.ol_flag[i] & ~ol_clr[i];
      if (oc_s[i] && st_reg.drive[i] && st_reg.oc_cnt[i] >= OC_FILTER) begin
        st_next.oc_flag[i] = 1'b1;
        st_next.cfg[i]     = CFG_OFF;
        st_next.oc_cnt[i]  = '0;
        st_next.drive[i]   = 1'b0;
      end else begin
        st_next.drive[i] = source_level(st_reg.cfg[i], timer_i, pwm_i) &
                           ~kill & ~cutoff;
      end
      if (ol_s[i] && st_reg.drive[i] && st_reg.ol_cnt[i] >= OL_FILTER) begin
        st_next.ol_flag[i] = 1'b1;
      end
    end
    // register read, answer one cycle later
    st_next.rd_data = RD_DATA_RESET;
    if (rd_en_i) begin
      case (addr_i)
        ADDR_CTRL_A:
          st_next.rd_data = {1'b0, st_reg.cfg[1], 1'b0, st_reg.cfg[0]};
        ADDR_CTRL_B:
          st_next.rd_data = {1'b0, st_reg.cfg[3], 1'b0, st_reg.cfg[2]};
        ADDR_SUPPLY_CFG:
          st_next.rd_data = {5'h00, st_reg.supply_cfg};
        ADDR_OC_STAT:
          st_next.rd_data = {4'h0, st_reg.oc_flag};
        ADDR_OL_STAT:
          st_next.rd_data = {4'h0, st_reg.ol_flag};
        ADDR_SUPPLY_STAT:
          st_next.rd_data = {st_reg.drive, under_s, over_s,
                             st_reg.under_flag, st_reg.over_flag};
        default:
          st_next.rd_data = RD_DATA_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg            <= '0;
      st_reg.cfg        <= {NUM_OUT{CFG_RESET}};
      st_reg.supply_cfg <= SUPPLY_CFG_RESET;
      st_reg.rd_data    <= RD_DATA_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rd_data_o          = st_reg.rd_data;
  assign high_side_output_o = st_reg.drive;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_kill_mode_off: assert property (
    kill |=> (high_side_output_o == 4'h0))
    else $error("output on in restart or fail-safe mode");

  a_supply_cut_off: assert property (
    cutoff |=> (high_side_output_o == 4'h0))
    else $error("output on during supply cut-off");

  a_no_recover_clear: assert property (
    (cutoff && no_recover) |=> (st_reg.cfg == '0))
    else $error("control fields kept without auto recovery");

  a_low_power_hold: assert property (
    (low_power && !(cutoff && no_recover) &&
     (oc_s & st_reg.drive) == 4'h0) |=>
    (st_reg.cfg == $past(st_reg.cfg)))
    else $error("configuration changed in low-power mode");

  a_kill_entry_clear: assert property (
    (kill && !st_reg.kill_prev) |=> (st_reg.cfg == '0))
    else $error("configuration kept on restart or fail-safe entry");

  a_supply_flag_set: assert property (
    (over_s && ((oc_s | ol_s) & st_reg.drive) == 4'h0) |=>
    (st_reg.over_flag &&
     ((st_reg.oc_flag | st_reg.ol_flag) &
      ~$past(st_reg.oc_flag | st_reg.ol_flag)) == 4'h0))
    else $error("supply fault flag missing or other flag set");

  a_under_flag_set: assert property (
    (under_s && ((oc_s | ol_s) & st_reg.drive) == 4'h0) |=>
    (st_reg.under_flag &&
     ((st_reg.oc_flag | st_reg.ol_flag) &
      ~$past(st_reg.oc_flag | st_reg.ol_flag)) == 4'h0))
    else $error("under-voltage flag missing or other flag set");

  a_read_timing: assert property (
    !rd_en_i |=> (rd_data_o == 8'h00))
    else $error("read data outside answer cycle");

  generate
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_chk
      a_oc_shutdown: assert property (
        (oc_s[g] && st_reg.drive[g] && st_reg.oc_cnt[g] >= OC_FILTER) |=>
        (!high_side_output_o[g] && st_reg.oc_flag[g] &&
         st_reg.cfg[g] == CFG_OFF))
        else $error("over-current shutdown incomplete");

      a_oc_not_early: assert property (
        (st_reg.drive[g] && st_reg.oc_cnt[g] < OC_FILTER) |=>
        !$rose(st_reg.oc_flag[g]))
        else $error("over-current flag set before filter time");

      a_oc_flag_sticky: assert property (
        (st_reg.oc_flag[g] && !oc_clr[g]) |=> st_reg.oc_flag[g])
        else $error("over-current flag lost without clear");

      a_ol_flag_sticky: assert property (
        (st_reg.ol_flag[g] && !ol_clr[g]) |=> st_reg.ol_flag[g])
        else $error("open-load flag lost without clear");

      a_ol_while_on: assert property (
        $rose(st_reg.ol_flag[g]) |-> $past(st_reg.drive[g], 1) &&
        $past(st_reg.ol_cnt[g], 1) >= OL_FILTER)
        else $error("open-load flag set while off or too early");

      a_oc_own_flag: assert property (
        $rose(st_reg.oc_flag[g]) |-> $past(oc_s[g] && st_reg.drive[g]))
        else $error("over-current flag set by another output");

      a_ol_keeps_on: assert property (
        (ol_s[g] && st_reg.drive[g] && !oc_s[g] && !kill && !cutoff &&
         source_level(st_reg.cfg[g], timer_i, pwm_i)) |=>
        high_side_output_o[g])
        else $error("open load switched the output off");

      a_oc_flag_clear: assert property (
        (st_reg.oc_flag[g] && oc_clr[g] && !oc_s[g]) |=> !st_reg.oc_flag[g])
        else $error("over-current flag not cleared by software");

      a_ol_flag_clear: assert property (
        (st_reg.ol_flag[g] && ol_clr[g] && !ol_s[g]) |=> !st_reg.ol_flag[g])
        else $error("open-load flag not cleared by software");
    end
  endgenerate

  c_oc_shutdown: cover property (
    $rose(st_reg.oc_flag[0]));
  c_ol_detect: cover property (
    $rose(st_reg.ol_flag[1]));
  c_supply_recover: cover property (
    cutoff && !no_recover ##1 !cutoff ##1 high_side_output_o[0]);
  c_kill_entry: cover property (
    !kill ##1 kill);
  c_low_power_write: cover property (
    low_power && wr_en_i);

endmodule : high_side_switch_protection
`default_nettype wire

// file: core/hs_pkg.sv
// constants and types for the high-side switch protection block
//
// How it works
// - each output follows its control field, a timer or a pwm generator
// - in stop or sleep the configuration holds and config writes are ignored; status clear writes still act
// - restart or fail-safe mode switches every output off
// - supply over-voltage cuts outputs unless disabled; they return on clear
// - supply under-voltage cuts outputs unless disabled; they return on clear
// - outputs resume their programmed state only with auto recovery set
// - without auto recovery a supply cut clears the control fields
// - supply faults set only the two supply status flags
// - over-current longer than the filter time switches the output off
// - over-current shutdown sets that output's over-current flag
// - over-current shutdown resets that output's field to off code 000
// - over-current flags stay set until software clears them
// - open load is checked only while on and sets the open-load flag
// - an open load leaves the output switched on
// - open-load flags stay set until software clears them
// - over-current filter time is 16 us on the internal clock
// - open load is reported after persisting 64 us
package hs_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_OUT = 4;
  localparam int ADDR_W  = 3;
  localparam int DATA_W  = 8;
  localparam int CFG_W   = 3;
  localparam int CNT_W   = 10;
  localparam int SYNC_W  = 10;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A      = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B      = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_SUPPLY_CFG  = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_OC_STAT     = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_OL_STAT     = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_SUPPLY_STAT = 3'h5;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_LO_POS      = 0;
  localparam int CTRL_HI_POS      = 4;
  localparam int SUP_OV_DIS_BIT   = 0;
  localparam int SUP_UV_DIS_BIT   = 1;
  localparam int SUP_RECOVER_BIT  = 2;
  localparam int STAT_OV_BIT      = 0;
  localparam int STAT_UV_BIT      = 1;
  localparam int STAT_OV_LIVE_BIT = 2;
  localparam int STAT_UV_LIVE_BIT = 3;
  localparam int STAT_DRIVE_POS   = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [CFG_W-1:0]  CFG_RESET        = 3'h0;
  localparam logic [2:0]        SUPPLY_CFG_RESET = 3'h0;
  localparam logic [DATA_W-1:0] RD_DATA_RESET    = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 10;
  localparam int OC_FILTER_US = 16;
  localparam int OL_FILTER_US = 64;
  localparam logic [CNT_W-1:0] OC_FILTER_CYCLES =
    CNT_W'(OC_FILTER_US * CLK_FREQ_MHZ);
  localparam logic [CNT_W-1:0] OL_FILTER_CYCLES =
    CNT_W'(OL_FILTER_US * CLK_FREQ_MHZ);

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CFG_OFF    = 3'b000,
    CFG_ON     = 3'b001,
    CFG_TIMER1 = 3'b010,
    CFG_TIMER2 = 3'b011,
    CFG_PWM1   = 3'b100,
    CFG_PWM2   = 3'b101
  } out_cfg_type;

  typedef enum logic [1:0] {
    MODE_NORMAL    = 2'b00,
    MODE_LOW_POWER = 2'b01,
    MODE_RESTART   = 2'b10,
    MODE_FAIL_SAFE = 2'b11
  } chip_mode_type;

endpackage : hs_pkg

// file: core/level_sync.sv
// two-stage synchroniser for asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_type;

  sync_state_type st_reg;
  sync_state_type st_next;

  always_comb begin
    st_next.stage1 = async_i;
    st_next.stage2 = st_reg.stage1;
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_o = st_reg.stage2;

endmodule : level_sync
`default_nettype wire

// file: verif/load_model.sv
// load model seen by the four switch drives
`timescale 1ns/10ps
`default_nettype none
module load_model
  import hs_pkg::*;
(
  // drive from the block
  input  wire logic [NUM_OUT-1:0] drive_i,
  // fault commands from the bench
  input  wire logic [NUM_OUT-1:0] short_i,
  input  wire logic [NUM_OUT-1:0] open_i,
  // comparator levels
  output logic      [NUM_OUT-1:0] overcurrent_o,
  output logic      [NUM_OUT-1:0] open_load_o
);
  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  // a switch that is off draws no current, so it reads as open load
  assign overcurrent_o = drive_i & short_i;
  assign open_load_o   = open_i | ~drive_i;
endmodule : load_model
`default_nettype wire

// file: verif/tb_high_side_switch_protection.sv
// self-checking bench for the high-side switch protection block
`timescale 1ns/10ps
`default_nettype none
module tb_high_side_switch_protection;
  import hs_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                core_clk_i;
  logic                sys_rst_i;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic                wr_en;
  logic                rd_en;
  logic [DATA_W-1:0]   rdata;
  chip_mode_type       mode;
  logic [1:0]          tmr;
  logic [1:0]          pwm;
  logic                s_over;
  logic                s_under;
  logic [NUM_OUT-1:0]  short_c;
  logic [NUM_OUT-1:0]  open_c;
  logic [NUM_OUT-1:0]  oc;
  logic [NUM_OUT-1:0]  ol;
  logic [NUM_OUT-1:0]  drv;
  logic [2:0]          codes [4];
  logic [NUM_OUT-1:0]  exp_d;
  int                  bad_count;
  int                  num_checks;
  // ----------------------------------------------------------------
  // instances
  // ----------------------------------------------------------------
  high_side_switch_protection #(
    .OC_FILTER(10'h004),
    .OL_FILTER(10'h008)
  ) high_side_switch_protection_i (
    .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
    .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en),
    .rd_data_o(rdata), .chip_mode_i(mode), .timer_i(tmr), .pwm_i(pwm),
    .supply_over_i(s_over), .supply_under_i(s_under),
    .overcurrent_i(oc), .open_load_i(ol), .high_side_output_o(drv)
  );
  load_model load_model_i (
    .drive_i(drv), .short_i(short_c), .open_i(open_c),
    .overcurrent_o(oc), .open_load_o(ol)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic wcyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : wcyc
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge core_clk_i);
    wr_en <= 1'b0;
  endtask : wr
  task automatic check_rd(input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] e);
    @(posedge core_clk_i);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge core_clk_i);
    rd_en <= 1'b0;
    #1;
    num_checks++;
    if (rdata !== e) begin
      bad_count++;
      $display("unexpected reg %0d exp %h got %h", a, e, rdata);
    end
  endtask : check_rd
  task automatic check_drv(input logic [NUM_OUT-1:0] e);
    num_checks++;
    if (drv !== e) begin
      bad_count++;
      $display("unexpected drive exp %h got %h", e, drv);
    end
  endtask : check_drv
  function automatic logic exp_bit(input logic [2:0] c, input logic [1:0] t,
                                   input logic [1:0] p);
    case (c)
      3'h1: return 1'b1;
      3'h2: return t[0];
      3'h3: return t[1];
      3'h4: return p[0];
      3'h5: return p[1];
      default: return 1'b0;
    endcase
  endfunction : exp_bit
  // ----------------------------------------------------------------
  // clock and watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end
  initial begin
    #(100 * 20000);
    bad_count++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    sys_rst_i = 1'b1; addr = '0; wdata = '0; wr_en = 1'b0; rd_en = 1'b0;
    mode = MODE_NORMAL; tmr = '0; pwm = '0; s_over = 1'b0; s_under = 1'b0;
    short_c = '0; open_c = '0; bad_count = 0; num_checks = 0;
    void'($urandom(38));
    repeat (4) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    wcyc(2);
    for (int a = 0; a < 8; a++) check_rd(3'(a), 8'h00);
    $display("test reset done");
    for (int n = 0; n < 16; n++) begin
      for (int k = 0; k < 4; k++) codes[k] = 3'($urandom % 8);
      if (n < 8) codes[0] = 3'(n);
      tmr <= 2'($urandom);
      pwm <= 2'($urandom);
      wr(ADDR_CTRL_A, {1'b0, codes[1], 1'b0, codes[0]});
      wr(ADDR_CTRL_B, {1'b0, codes[3], 1'b0, codes[2]});
      wcyc(3);
      for (int k = 0; k < 4; k++) exp_d[k] = exp_bit(codes[k], tmr, pwm);
      check_drv(exp_d);
    end
    $display("test sources done");
    wr(ADDR_CTRL_A, 8'h11);
    wr(ADDR_CTRL_B, 8'h00);
    mode <= MODE_LOW_POWER;
    wr(ADDR_CTRL_A, 8'h00);
    wcyc(3);
    check_rd(ADDR_CTRL_A, 8'h11);
    check_drv(4'h3);
    for (int m = 2; m < 4; m++) begin
      mode <= chip_mode_type'(m);
      wcyc(3);
      check_drv(4'h0);
      mode <= MODE_NORMAL;
      wcyc(3);
      check_drv(4'h0);
      wr(ADDR_CTRL_A, 8'h11);
      wcyc(3);
      check_drv(4'h3);
    end
    $display("test modes done");
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_SUPPLY_CFG, 8'h04);
      wr(ADDR_CTRL_A, 8'h11);
      wr(ADDR_CTRL_B, 8'h11);
      {s_under, s_over} <= 2'(1 << k);
      wcyc(5);
      check_drv(4'h0);
      check_rd(ADDR_SUPPLY_STAT, 8'((1 << k) | (4 << k)));
      check_rd(ADDR_OC_STAT, 8'h00);
      check_rd(ADDR_OL_STAT, 8'h00);
      {s_under, s_over} <= 2'b00;
      wcyc(5);
      check_drv(4'hf);
      wr(ADDR_SUPPLY_STAT, 8'h03);
      wr(ADDR_SUPPLY_CFG, 8'(4 | (1 << k)));
      {s_under, s_over} <= 2'(1 << k);
      wcyc(5);
      check_drv(4'hf);
      {s_under, s_over} <= 2'b00;
      wr(ADDR_SUPPLY_CFG, 8'h00);
      wcyc(3);
      {s_under, s_over} <= 2'(1 << k);
      wcyc(5);
      {s_under, s_over} <= 2'b00;
      wcyc(5);
      check_drv(4'h0);
      check_rd(ADDR_CTRL_B, 8'h00);
      wr(ADDR_SUPPLY_STAT, 8'h03);
    end
    $display("test supply done");
    wr(ADDR_CTRL_A, 8'h11);
    short_c <= 4'h2;
    wcyc(20);
    check_drv(4'h1);
    check_rd(ADDR_OC_STAT, 8'h02);
    check_rd(ADDR_CTRL_A, 8'h01);
    short_c <= 4'h0;
    wcyc(5);
    check_rd(ADDR_OC_STAT, 8'h02);
    wr(ADDR_OC_STAT, 8'h02);
    check_rd(ADDR_OC_STAT, 8'h00);
    wr(ADDR_CTRL_A, 8'h11);
    wcyc(3);
    check_drv(4'h3);
    $display("test overcurrent done");
    open_c <= 4'h1;
    wcyc(30);
    check_drv(4'h3);
    check_rd(ADDR_OL_STAT, 8'h01);
    open_c <= 4'h0;
    wcyc(5);
    check_rd(ADDR_OL_STAT, 8'h01);
    wr(ADDR_OL_STAT, 8'h01);
    check_rd(ADDR_OL_STAT, 8'h00);
    $display("test open load done");
    complete_run();
  end
endmodule : tb_high_side_switch_protection
`default_nettype wire
